// >>> s2chk_pkg.sv
package s2chk_pkg;

    // APB register byte offsets
    localparam logic [11:0] CTRL_OFS     = 12'h000;
    localparam logic [11:0] DEFPASID_OFS = 12'h004;
    localparam logic [11:0] CAP_OFS      = 12'h008;
    localparam logic [11:0] FAULT_OFS    = 12'h00c;

    // Control register fields
    localparam int          CTRL_TRACK_BIT = 0;
    localparam int          CTRL_EXEC_BIT  = 1;
    localparam int          CTRL_XT_LSB    = 4;
    localparam logic [2:0]  XT_RESET       = 3'h2;
    localparam logic [2:0]  XT_NESTED      = 3'h3;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0020;
    localparam logic [31:0] CTRL_WMASK     = 32'h0000_0073;

    // Capability and fault status fields
    localparam int          CAP_TRACK_BIT   = 0;
    localparam int          FAULT_SEEN_BIT  = 0;
    localparam int          FAULT_NOXL_BIT  = 1;
    localparam int          FAULT_STAGE_LSB = 4;
    localparam int          FAULT_CNT_LSB   = 16;
    localparam logic [31:0] DEFPASID_RESET  = 32'h0000_0000;

    // Second-level entry layout
    localparam int          ENT_R  = 0;
    localparam int          ENT_W  = 1;
    localparam int          ENT_X  = 2;
    localparam int          ENT_PS = 7;
    localparam int          ENT_A  = 8;
    localparam int          ENT_D  = 9;
    // Address bits 51 down to a 48-bit host address width are reserved
    localparam logic [63:0] ENT_RSVD_MASK = 64'h000f_0000_0000_0000;

    typedef enum logic [2:0] {
        K_DREAD,
        K_FETCH,
        K_WRITE,
        K_ATOMIC,
        K_FL_READ,
        K_FL_FLAGUPD,
        K_HPA
    } kind_t;

    typedef struct packed {
        kind_t       kind;
        logic        execute_requested;
        logic        has_pasid;
        logic [19:0] pasid;
        logic [2:0]  stage;
    } chk_req_t;

    typedef struct packed {
        logic        fault;
        logic        no_xlate;
        logic [2:0]  stage;
        logic [19:0] pasid;
    } chk_res_t;

endpackage

// >>> stage2_access_rights_checker.sv
// Behaviour
// R1: Fault on missing translation or forbidden access.
// R2: Data read needs read bit everywhere.
// R3: Fetch without exec enable needs read only.
// R4: Fetch with exec enable needs read and execute.
// R5: Write needs write bit everywhere.
// R6: Atomic needs read and write bits.
// R7: Cached rights may hide memory changes.
// R8: Tracking capability reported; enable bit per context (here one CTRL_TRACK_BIT for all requests).
// R9: Bit 8 is accessed flag when tracking.
// R10: Bit 9 of leaf is dirty flag.
// R11: Set accessed flag of each used entry.
// R12: On writes set leaf dirty flag.
// R13: Hardware never clears accessed or dirty flags.
// R14: Translation type 011b selects nested translation.
// R15: Requests without PASID use default PASID.
// R16: Nested first-level accesses pass second-level checks.
// R17: Root, context and PASID tables bypass stages.
// R18: Nested checks fault at any stage.
// R19: Untracked first-level entry read needs read.
// R20: Untracked first-level flag update needs read, write.
// R21: Tracked first-level accesses need read and write.
// R22: Nested final access uses per-type checks.
// R23: Entry without read/write or reserved bits faults.
// R24: Execute bit ignored for requests without PASID.
// R25: Report failing stage and cause; block faults.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stage2_access_rights_checker
    import s2chk_pkg::*;
#(
    parameter bit TRACK_CAP = 1'b1
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // APB register slave
    input  wire logic [11:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Check request from the walker
    input  wire logic                req_valid,
    output logic                     req_ready,
    input  wire s2chk_pkg::chk_req_t req,
    // Second-level entries, root first
    input  wire logic                ent_valid,
    output logic                     ent_ready,
    input  wire logic [63:0]         ent_data,
    input  wire logic                ent_leaf,
    // Flag write-back of an entry
    output logic                     upd_valid,
    input  wire logic                upd_ready,
    output logic [63:0]              upd_data,
    // Result to grant or fault path
    output logic                     res_valid,
    input  wire logic                res_ready,
    output s2chk_pkg::chk_res_t      res
);
    import s2chk_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_WALK, S_UPD, S_DONE} state_t;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Stage-1 table kinds only see second-level checks in nested mode
    function automatic logic is_bypass(input kind_t k, input logic nested);
        return (k == K_HPA) || (!nested && (k == K_FL_READ || k == K_FL_FLAGUPD));
    endfunction

    state_t      state_r;
    chk_req_t    req_r;
    logic        fault_r;
    logic        noxl_r;
    logic        end_r;
    logic [63:0] upd_r;
    logic [31:0] ctrl_r;
    logic [31:0] defpasid_r;
    logic        fseen_r;
    logic        fnoxl_r;
    logic [2:0]  fstage_r;
    logic [15:0] fcnt_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;

    // Register access
    wire         setup_ph  = psel && !penable;
    wire         wr_en     = psel && penable && pwrite;
    wire         hit_ctrl  = paddr == CTRL_OFS;
    wire         hit_defp  = paddr == DEFPASID_OFS;
    wire         hit_cap   = paddr == CAP_OFS;
    wire         hit_fault = paddr == FAULT_OFS;
    wire         mapped    = hit_ctrl || hit_defp || hit_cap || hit_fault;
    wire [31:0]  cap_word  = {31'h0, TRACK_CAP};
    wire [31:0]  flt_word  = {fcnt_r, 9'h0, fstage_r, 2'h0, fnoxl_r, fseen_r};
    wire [31:0]  rd_word   = hit_ctrl ? ctrl_r : hit_defp ? defpasid_r :
                             hit_cap ? cap_word : hit_fault ? flt_word : 32'h0;
    wire [31:0]  ctrl_wr   = merge_bytes(ctrl_r, pwdata, pstrb) & CTRL_WMASK;
    wire [31:0]  defp_wr   = merge_bytes(defpasid_r, pwdata, pstrb) & 32'h000f_ffff;

    // Effective controls
    wire         track_on  = ctrl_r[CTRL_TRACK_BIT] && TRACK_CAP; // [R8]
    wire         exec_en   = ctrl_r[CTRL_EXEC_BIT];
    wire [2:0]   xt        = ctrl_r[CTRL_XT_LSB +: 3];
    wire         nested    = xt == XT_NESTED; // [R14]

    // Handshakes
    wire         req_fire  = req_valid && req_ready;
    wire         ent_fire  = ent_valid && ent_ready;
    wire         upd_fire  = upd_valid && upd_ready;
    wire         res_fire  = res_valid && res_ready;

    // Rights needed by the pending access
    wire         k_fetch   = req_r.kind == K_FETCH || (req_r.kind == K_DREAD && req_r.execute_requested);
    // Writes need only the write bit; every other kind needs read
    wire         need_r    = req_r.kind != K_WRITE; // [R2] [R3] [R6] [R19]
    wire         need_w    = req_r.kind == K_WRITE || req_r.kind == K_ATOMIC || // [R5] [R6] [R22]
                             req_r.kind == K_FL_FLAGUPD || // [R20]
                             (req_r.kind == K_FL_READ && track_on); // [R21]
    wire         need_x    = k_fetch && exec_en && req_r.has_pasid; // [R4] [R24]

    // Entry checks
    wire         ent_usable = (ent_data[ENT_R] || ent_data[ENT_W]) && // [R23]
                              ((ent_data & ENT_RSVD_MASK) == 64'h0);
    wire         perm_ok    = (!need_r || ent_data[ENT_R]) && (!need_w || ent_data[ENT_W]) &&
                              (!need_x || ent_data[ENT_X]);
    wire         set_a      = track_on && !ent_data[ENT_A]; // [R9] [R11]
    wire         set_d      = track_on && ent_leaf && perm_ok && need_w && !ent_data[ENT_D]; // [R10] [R12]
    wire [63:0]  flag_bits  = {54'h0, set_d, set_a, 8'h0};
    wire         walk_end   = ent_leaf || !perm_ok;

    assign pready    = 1'b1;
    assign prdata    = prdata_r;
    assign pslverr   = pslverr_r;
    assign req_ready = state_r == S_IDLE;
    assign ent_ready = state_r == S_WALK;
    assign upd_valid = state_r == S_UPD;
    assign upd_data  = upd_r;
    assign res_valid = state_r == S_DONE;
    // Grant only when fault is low; a fault blocks the request
    assign res       = '{fault: fault_r, no_xlate: noxl_r, stage: req_r.stage, pasid: req_r.pasid}; // [R25]

    // Read data is captured in the setup phase so that zero-wait access is from a flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= pwrite ? 32'h0 : rd_word;
            pslverr_r <= !mapped;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r     <= CTRL_RESET;
            defpasid_r <= DEFPASID_RESET;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                ctrl_r <= ctrl_wr;
            end
            if (hit_defp) begin
                defpasid_r <= defp_wr;
            end
        end
    end

    // Last fault and count, read-only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fseen_r  <= 1'b0;
            fnoxl_r  <= 1'b0;
            fstage_r <= 3'h0;
            fcnt_r   <= 16'h0;
        end else if (res_fire && fault_r) begin
            fseen_r  <= 1'b1;
            fnoxl_r  <= noxl_r;
            fstage_r <= req_r.stage; // [R18]
            fcnt_r   <= fcnt_r + 16'h0001;
        end
    end

    // No translation cache here: every check uses the entries presented [R7]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            req_r   <= '0;
            fault_r <= 1'b0;
            noxl_r  <= 1'b0;
            end_r   <= 1'b0;
            upd_r   <= 64'h0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (req_fire) begin
                        req_r   <= req;
                        if (!req.has_pasid) begin
                            req_r.pasid <= defpasid_r[19:0]; // [R15]
                        end
                        fault_r <= 1'b0;
                        noxl_r  <= 1'b0;
                        state_r <= is_bypass(req.kind, nested) ? S_DONE : S_WALK; // [R16] [R17]
                    end
                end
                S_WALK: begin
                    if (ent_fire) begin
                        if (!ent_usable) begin
                            fault_r <= 1'b1; // [R1] [R23]
                            noxl_r  <= 1'b1;
                            state_r <= S_DONE;
                        end else begin
                            fault_r <= !perm_ok; // [R1] [R22]
                            end_r   <= walk_end;
                            upd_r   <= ent_data | flag_bits; // [R13]
                            if (set_a || set_d) begin
                                state_r <= S_UPD;
                            end else if (walk_end) begin
                                state_r <= S_DONE;
                            end
                        end
                    end
                end
                S_UPD: begin
                    if (upd_fire) begin
                        state_r <= end_r ? S_DONE : S_WALK;
                    end
                end
                S_DONE: begin
                    if (res_fire) begin
                        state_r <= S_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_invalid_entry;
        ent_fire && !ent_usable |=> fault_r && noxl_r && state_r == S_DONE;
    endproperty
    a_invalid_entry: assert property (p_invalid_entry) else $error("unusable entry did not fault"); // [R23]

    property p_write_perm;
        ent_fire && ent_usable && req_r.kind == K_WRITE && !ent_data[ENT_W] |=> fault_r && !noxl_r;
    endproperty
    a_write_perm: assert property (p_write_perm) else $error("write without write bit passed"); // [R5]

    property p_fetch_exec;
        ent_fire && ent_usable && req_r.kind == K_FETCH && exec_en && req_r.has_pasid && !ent_data[ENT_X]
            |=> fault_r;
    endproperty
    a_fetch_exec: assert property (p_fetch_exec) else $error("fetch without execute bit passed"); // [R4]

    property p_nopasid_x;
        ent_fire && ent_usable && req_r.kind == K_FETCH && !req_r.has_pasid && ent_data[ENT_R] |=> !fault_r;
    endproperty
    a_nopasid_x: assert property (p_nopasid_x) else $error("execute bit used without PASID"); // [R24]

    property p_hpa_bypass;
        req_fire && req.kind == K_HPA |=> state_r == S_DONE && !fault_r;
    endproperty
    a_hpa_bypass: assert property (p_hpa_bypass) else $error("table fetch was not bypassed"); // [R17]

    property p_default_pasid;
        req_fire && !req.has_pasid |=> req_r.pasid == defpasid_r[19:0];
    endproperty
    a_default_pasid: assert property (p_default_pasid) else $error("default PASID not applied"); // [R15]

    property p_nested_fl;
        req_fire && req.kind == K_FL_READ && nested |=> state_r == S_WALK;
    endproperty
    a_nested_fl: assert property (p_nested_fl) else $error("nested table read skipped checks"); // [R16]

    property p_accessed;
        ent_fire && ent_usable && track_on && !ent_data[ENT_A] |=> upd_valid && upd_data[ENT_A];
    endproperty
    a_accessed: assert property (p_accessed) else $error("accessed flag not set"); // [R11]

    property p_dirty;
        ent_fire && ent_usable && ent_leaf && track_on && req_r.kind == K_WRITE &&
            ent_data[ENT_W] && !ent_data[ENT_D] |=> upd_valid && upd_data[ENT_D];
    endproperty
    a_dirty: assert property (p_dirty) else $error("dirty flag not set"); // [R12]

    property p_no_clear;
        ent_fire && ent_usable |=> !upd_valid || ((upd_data & $past(ent_data)) == $past(ent_data));
    endproperty
    a_no_clear: assert property (p_no_clear) else $error("write-back cleared a bit"); // [R13]

    property p_no_update_untracked;
        !track_on && ent_fire |=> !upd_valid;
    endproperty
    a_no_update_untracked: assert property (p_no_update_untracked) else $error("update while untracked"); // [R8]

    property p_res_hold;
        res_valid && !res_ready |=> res_valid && $stable(res);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result changed before taken"); // [R25]

    property p_read_perm;
        ent_fire && ent_usable && req_r.kind == K_DREAD && !req_r.execute_requested && !ent_data[ENT_R]
            |=> fault_r && !noxl_r;
    endproperty
    a_read_perm: assert property (p_read_perm) else $error("read without read bit passed"); // [R2]

    property p_fetch_noexec;
        ent_fire && ent_usable && k_fetch && !exec_en && ent_data[ENT_R] |=> !fault_r;
    endproperty
    a_fetch_noexec: assert property (p_fetch_noexec) else $error("fetch refused with read bit"); // [R3]

    property p_write_no_read;
        ent_fire && ent_usable && req_r.kind == K_WRITE && ent_data[ENT_W] |=> !fault_r;
    endproperty
    a_write_no_read: assert property (p_write_no_read) else $error("write refused with write bit"); // [R5]

    property p_atomic_perm;
        ent_fire && ent_usable && req_r.kind == K_ATOMIC && !(ent_data[ENT_R] && ent_data[ENT_W]) |=> fault_r;
    endproperty
    a_atomic_perm: assert property (p_atomic_perm) else $error("atomic without both bits passed"); // [R6]

    property p_fl_read_untracked;
        ent_fire && ent_usable && req_r.kind == K_FL_READ && !track_on |=> fault_r != $past(ent_data[ENT_R]);
    endproperty
    a_fl_read_untracked: assert property (p_fl_read_untracked) else $error("table read rights wrong"); // [R19]

    property p_fl_flagupd;
        ent_fire && ent_usable && req_r.kind == K_FL_FLAGUPD && !ent_data[ENT_W] |=> fault_r;
    endproperty
    a_fl_flagupd: assert property (p_fl_flagupd) else $error("flag update without write passed"); // [R20]

    property p_fl_tracked;
        ent_fire && ent_usable && req_r.kind == K_FL_READ && track_on && !ent_data[ENT_W] |=> fault_r;
    endproperty
    a_fl_tracked: assert property (p_fl_tracked) else $error("tracked table read without write"); // [R21]

    property p_fl_bypass;
        req_fire && !nested && (req.kind == K_FL_READ || req.kind == K_FL_FLAGUPD) |=> state_r == S_DONE;
    endproperty
    a_fl_bypass: assert property (p_fl_bypass) else $error("table access checked outside nesting"); // [R14]

    property p_fault_logged;
        res_fire && fault_r |=> fseen_r && fstage_r == $past(req_r.stage);
    endproperty
    a_fault_logged: assert property (p_fault_logged) else $error("fault stage not logged"); // [R25]

    property p_accessed_pos;
        upd_valid |-> upd_data[ENT_A];
    endproperty
    a_accessed_pos: assert property (p_accessed_pos) else $error("write-back without accessed flag"); // [R9]

    property p_dirty_leaf_only;
        ent_fire && ent_usable && !ent_leaf && !ent_data[ENT_D] |=> !upd_valid || !upd_data[ENT_D];
    endproperty
    a_dirty_leaf_only: assert property (p_dirty_leaf_only) else $error("dirty set on table entry"); // [R10]

    property p_walk_stops;
        ent_fire && ent_usable && !perm_ok |=> !ent_ready;
    endproperty
    a_walk_stops: assert property (p_walk_stops) else $error("walk went on after a fault"); // [R18]

endmodule
`default_nettype wire

// >>> s2_walk_model.sv
`timescale 1ns/1ps
`default_nettype none
module s2_walk_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Entry stream, root first
    output logic             ent_valid,
    input  wire logic        ent_ready,
    output logic [63:0]      ent_data,
    output logic             ent_leaf,
    // Flag write-back
    input  wire logic        upd_valid,
    output logic             upd_ready,
    input  wire logic [63:0] upd_data
);
    logic [63:0] mem [2];
    int          n     = 0;
    int          idx   = 0;
    int          n_upd = 0;
    logic        slow  = 1'b0;
    logic        gap   = 1'b0;
    logic        held  = 1'b0;
    logic        tog   = 1'b0;

    // Rights always read from memory, never from a cached copy
    assign ent_valid = idx < n && !gap;
    // Released lines toggle so a stale entry is never seen as valid data
    assign ent_data  = ent_valid ? mem[idx] : {64{tog}};
    assign ent_leaf  = ent_valid ? idx == n - 1 : tog;
    assign upd_ready = upd_valid && (held || !slow);

    task automatic load(input logic [63:0] e0, input logic [63:0] e1, input int cnt, input logic s);
        mem[0] = e0;
        mem[1] = e1;
        n      = cnt;
        idx    = 0;
        slow   = s;
    endtask

    always @(posedge clk) begin
        tog <= !tog;
        if (sys_rst) begin
            held <= 1'b0;
            gap  <= 1'b0;
        end else begin
            held <= upd_valid && !upd_ready;
            gap  <= slow && ent_valid && ent_ready;
            if (ent_valid && ent_ready)
                idx <= idx + 1;
            // Store only what is handed back; the model itself never clears a flag
            if (upd_valid && upd_ready) begin
                mem[idx - 1] <= upd_data;
                n_upd        <= n_upd + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> stage2_access_rights_checker_bench.sv
`timescale 1ns/1ps
`default_nettype none
module stage2_access_rights_checker_bench;
    import s2chk_pkg::*;
    logic        clk       = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic        req_valid = 1'b0;
    logic        res_ready = 1'b1;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [3:0]  pstrb     = 4'hf;
    chk_req_t    req       = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, req_ready, ent_valid, ent_ready, ent_leaf, upd_valid, upd_ready, res_valid;
    logic [63:0] ent_data, upd_data;
    chk_res_t    res;
    int          n_mismatch = 0;
    int          n_checks   = 0;

    stage2_access_rights_checker uut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .ent_valid(ent_valid), .ent_ready(ent_ready), .ent_data(ent_data), .ent_leaf(ent_leaf),
        .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_data(upd_data), .res_valid(res_valid),
        .res_ready(res_ready), .res(res));
    s2_walk_model walk (.clk(clk), .sys_rst(sys_rst), .ent_valid(ent_valid), .ent_ready(ent_ready),
        .ent_data(ent_data), .ent_leaf(ent_leaf), .upd_valid(upd_valid), .upd_ready(upd_ready),
        .upd_data(upd_data));

    always #50 clk = ~clk;

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic sig(input int w);
        return w == 0 ? pready : w == 1 ? req_ready : res_valid;
    endfunction

    // Sampled between edges so settled combinational outputs are seen
    task automatic wait_hi(input int w);
        int t;
        t = 0;
        @(negedge clk);
        while (sig(w) !== 1'b1 && t < 300) begin
            @(negedge clk);
            t++;
        end
        if (sig(w) !== 1'b1)
            n_mismatch++;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int t;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        // Request stands until pready is seen high at a rising edge
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 300);
        if (pready !== 1'b1)
            n_mismatch++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [63:0] pe(input logic [2:0] xwr, input logic ad, input logic rs);
        return 64'h0000_0000_1234_5000 | 64'(xwr) | 64'({ad, ad, 8'h00}) | (rs ? 64'h0001_0000_0000_0000 : 64'h0);
    endfunction

    task automatic run(input logic [31:0] ctrl, input kind_t k, input logic er, input logic hp,
                       input logic [63:0] e0, input logic [63:0] e1, input int cnt, input logic s,
                       input logic [2:0] st);
        logic [31:0] q;
        logic        e, f, nx, nr, nw, nxp;
        logic [63:0] en;
        apb(1'b1, CTRL_OFS, ctrl, q, e);
        walk.load(e0, e1, cnt, s);
        nr  = k != K_WRITE;
        nw  = k == K_WRITE || k == K_ATOMIC || k == K_FL_FLAGUPD || (k == K_FL_READ && ctrl[0]);
        nxp = hp && ctrl[1] && (k == K_FETCH || (k == K_DREAD && er));
        f   = 1'b0;
        nx  = 1'b0;
        if (k != K_HPA && (ctrl[6:4] == XT_NESTED || k < K_FL_READ))
            for (int i = 0; i < cnt; i++) begin
                en = i == 0 ? e0 : e1;
                if (!f) begin
                    nx = en[1:0] == 2'b00 || (en & ENT_RSVD_MASK) != 64'h0;
                    f  = nx || (nr && !en[0]) || (nw && !en[1]) || (nxp && !en[2]);
                end
            end
        @(posedge clk);
        req_valid <= 1'b1;
        res_ready <= !s;
        req       <= '{k, er, hp, 20'h00abc, st};
        wait_hi(1);
        @(posedge clk);
        req_valid <= 1'b0;
        wait_hi(2);
        chk("fault", 64'(f), 64'(res.fault));
        chk("no_xlate", 64'(nx), 64'(res.no_xlate));
        chk("stage", 64'(st), 64'(res.stage));
        chk("pasid", hp ? 64'h00abc : 64'h5a5a5, 64'(res.pasid));
        @(posedge clk);
        // Slow runs hold the result back one cycle before taking it
        res_ready <= 1'b1;
        @(posedge clk);
        $display("Test kind %0d stage %0d done", k, st);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict;
    end

    initial begin
        logic [31:0] q;
        logic        e;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, CTRL_OFS, 32'h0, q, e);
        chk("ctrl reset", CTRL_RESET, 64'(q));
        apb(1'b0, CAP_OFS, 32'h0, q, e);
        chk("track cap", 64'h1, 64'(q[CAP_TRACK_BIT]));
        apb(1'b0, 12'h010, 32'h0, q, e);
        chk("unmapped err", 64'h1, 64'(e));
        apb(1'b1, DEFPASID_OFS, 32'h0005_a5a5, q, e);
        run(32'h20, K_DREAD, 1'b0, 1'b1, pe(3'b001, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd0);
        run(32'h20, K_DREAD, 1'b0, 1'b1, pe(3'b001, 1, 0), pe(3'b010, 1, 0), 2, 1, 3'd0);
        run(32'h20, K_FETCH, 1'b1, 1'b1, pe(3'b001, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd0);
        run(32'h22, K_FETCH, 1'b1, 1'b1, pe(3'b101, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd0);
        run(32'h22, K_DREAD, 1'b1, 1'b1, pe(3'b101, 1, 0), pe(3'b101, 1, 0), 2, 0, 3'd0);
        run(32'h22, K_FETCH, 1'b1, 1'b0, pe(3'b001, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd0);
        run(32'h20, K_WRITE, 1'b0, 1'b1, pe(3'b010, 1, 0), pe(3'b011, 1, 0), 2, 0, 3'd0);
        run(32'h20, K_WRITE, 1'b0, 1'b1, pe(3'b011, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd0);
        run(32'h20, K_ATOMIC, 1'b0, 1'b1, pe(3'b011, 1, 0), pe(3'b011, 1, 0), 2, 0, 3'd0);
        run(32'h20, K_ATOMIC, 1'b0, 1'b1, pe(3'b011, 1, 0), pe(3'b010, 1, 0), 2, 0, 3'd0);
        run(32'h30, K_FL_READ, 1'b0, 1'b1, pe(3'b001, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd2);
        run(32'h30, K_FL_FLAGUPD, 1'b0, 1'b1, pe(3'b011, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd3);
        run(32'h31, K_FL_READ, 1'b0, 1'b0, pe(3'b011, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd6);
        run(32'h30, K_WRITE, 1'b0, 1'b1, pe(3'b011, 1, 0), pe(3'b001, 1, 0), 2, 0, 3'd0);
        run(32'h20, K_FL_FLAGUPD, 1'b0, 1'b1, pe(3'b000, 1, 0), pe(3'b000, 1, 0), 2, 0, 3'd4);
        run(32'h30, K_HPA, 1'b0, 1'b1, pe(3'b000, 1, 0), pe(3'b000, 1, 0), 2, 0, 3'd5);
        run(32'h20, K_DREAD, 1'b0, 1'b1, pe(3'b001, 1, 0), pe(3'b000, 1, 0), 2, 0, 3'd7);
        run(32'h20, K_DREAD, 1'b0, 1'b1, pe(3'b001, 1, 0), pe(3'b011, 1, 1), 2, 1, 3'd7);
        apb(1'b0, FAULT_OFS, 32'h0, q, e);
        chk("fault seen", 64'h1, 64'(q[FAULT_SEEN_BIT]));
        run(32'h21, K_WRITE, 1'b0, 1'b1, pe(3'b011, 0, 0), 64'h0, 1, 1, 3'd0);
        chk("leaf dirty", pe(3'b011, 1, 0), walk.mem[0]);
        run(32'h21, K_DREAD, 1'b0, 1'b1, pe(3'b011, 0, 0), pe(3'b001, 0, 0), 2, 0, 3'd0);
        chk("upper accessed", pe(3'b011, 0, 0) | 64'h100, walk.mem[0]);
        chk("leaf no dirty on read", pe(3'b001, 0, 0) | 64'h100, walk.mem[1]);
        run(32'h21, K_DREAD, 1'b0, 1'b1, walk.mem[0], walk.mem[1], 2, 1, 3'd0);
        chk("update count", 64'd3, 64'(walk.n_upd));
        chk("flags kept", pe(3'b001, 0, 0) | 64'h100, walk.mem[1]);
        give_verdict;
    end
endmodule
`default_nettype wire
